// >>> shared/mps_map.svh
// Offsets, field positions, reset values and sizes of the status flag block
`ifndef MPS_MAP_SVH
`define MPS_MAP_SVH
// ==========================================================
// Register map
`define MPS_FLAGS_OFS          8'h08
`define MPS_FLAGS_RST          13'h0040
`define MPS_FLAGS_W            13
// ==========================================================
// Field positions
`define MPS_BIT_CTRL_PROTECT   4'hC
`define MPS_BIT_TX_CHECKSUM    4'hB
`define MPS_BIT_STAMP_C        4'hA
`define MPS_BIT_STAMP_B        4'h9
`define MPS_BIT_STAMP_A        4'h8
`define MPS_BIT_PHY_IRQ        4'h7
`define MPS_BIT_RESET_DONE     4'h6
`define MPS_BIT_HDR_PARITY     4'h5
`define MPS_BIT_FRAME_LOSS     4'h4
`define MPS_BIT_RX_OVERFLOW    4'h3
`define MPS_BIT_TX_UNDERRUN    4'h2
`define MPS_BIT_TX_OVERFLOW    4'h1
`define MPS_BIT_TX_PROTOCOL    4'h0
// ==========================================================
// Host transmit FIFO size in bytes
`define MPS_TX_FIFO_BYTES      13'h1000
`endif

// >>> shared/mps_pkg.sv
// Types shared by the status flag block and its crossings
`default_nettype none
package mps_pkg;
  // ==========================================================
  // Link-side events, one pulse each
  typedef struct packed {
    logic ctrl_protect;
    logic hdr_parity;
    logic frame_loss;
    logic chunk_order;
  } mps_lk_evt_t;
  // ==========================================================
  // Register access carried from the link to the system clock
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } mps_acc_t;
  // ==========================================================
  // Data chunk framing state
  typedef enum logic [0:0] {
    MPS_FR_IDLE = 1'b0,
    MPS_FR_OPEN = 1'b1
  } mps_frame_t;
endpackage
`default_nettype wire

// >>> rtl/mps_evt_cdc.sv
// Toggle crossing that carries event pulses into another clock domain
`default_nettype none
module mps_evt_cdc #(
  parameter int W = 1
) (
  // Source side
  input  wire logic         src_clk,
  input  wire logic         src_rst_b,
  input  wire logic [W-1:0] src_pulse,
  // Destination side
  input  wire logic         dst_clk,
  input  wire logic         dst_rst_b,
  output logic      [W-1:0] dst_pulse
);
  logic [W-1:0] tog_reg, tog_next;
  logic [W-1:0] s1_reg, s2_reg, s3_reg, pulse_next;

  always_comb begin
    tog_next   = tog_reg ^ src_pulse;
    pulse_next = s2_reg ^ s3_reg;
  end

  always_ff @(posedge src_clk or negedge src_rst_b) begin
    if (!src_rst_b) begin
      tog_reg <= '0;
    end else begin
      tog_reg <= tog_next;
    end
  end

  always_ff @(posedge dst_clk or negedge dst_rst_b) begin
    if (!dst_rst_b) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      s3_reg    <= '0;
      dst_pulse <= '0;
    end else begin
      s1_reg    <= tog_reg;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      dst_pulse <= pulse_next;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/mps_hs_cdc.sv
// Four-phase-free toggle handshake that carries one held word across clocks
`default_nettype none
module mps_hs_cdc #(
  parameter int W = 8
) (
  // Source side
  input  wire logic         src_clk,
  input  wire logic         src_rst_b,
  input  wire logic         src_go,
  input  wire logic [W-1:0] src_data,
  output logic              src_done,
  // Destination side
  input  wire logic         dst_clk,
  input  wire logic         dst_rst_b,
  output logic              dst_stb,
  output logic      [W-1:0] dst_data
);
  logic         req_reg, req_next;
  logic [W-1:0] hold_reg, hold_next;
  logic         a1_reg, a2_reg, a3_reg, done_next;
  logic         r1_reg, r2_reg, r3_reg, stb_next;
  // Acknowledge leaves one cycle after the strobe, so a reply registered on it has settled
  logic         ack_reg;
  logic [W-1:0] data_next;

  // Payload stays still from the request toggle until the next go
  always_comb begin
    req_next  = req_reg ^ src_go;
    hold_next = src_go ? src_data : hold_reg;
    done_next = a2_reg ^ a3_reg;
    stb_next  = r2_reg ^ r3_reg;
    data_next = stb_next ? hold_reg : dst_data;
  end

  always_ff @(posedge src_clk or negedge src_rst_b) begin
    if (!src_rst_b) begin
      req_reg  <= 1'b0;
      hold_reg <= '0;
      a1_reg   <= 1'b0;
      a2_reg   <= 1'b0;
      a3_reg   <= 1'b0;
      src_done <= 1'b0;
    end else begin
      req_reg  <= req_next;
      hold_reg <= hold_next;
      a1_reg   <= ack_reg;
      a2_reg   <= a1_reg;
      a3_reg   <= a2_reg;
      src_done <= done_next;
    end
  end

  always_ff @(posedge dst_clk or negedge dst_rst_b) begin
    if (!dst_rst_b) begin
      r1_reg   <= 1'b0;
      r2_reg   <= 1'b0;
      r3_reg   <= 1'b0;
      ack_reg  <= 1'b0;
      dst_stb  <= 1'b0;
      dst_data <= '0;
    end else begin
      r1_reg   <= req_reg;
      r2_reg   <= r1_reg;
      r3_reg   <= r2_reg;
      ack_reg  <= r3_reg;
      dst_stb  <= stb_next;
      dst_data <= data_next;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/mps_status_flags.sv
// Sticky error and event flag register of the SPI MAC-PHY
`default_nettype none
`include "mps_map.svh"
module mps_status_flags #(
  parameter bit CDP_IMPL = 1'b1
) (
  // Clocks and reset
  input  wire logic        clk,
  input  wire logic        lk_clk,
  input  wire logic        rst_b,
  // Configuration levels, system clock
  input  wire logic        proto_std,
  input  wire logic        cdp_en,
  input  wire logic        cut_through_en,
  input  wire logic        exst_mask,
  input  wire logic [12:0] irq_unmask,
  // PHY interrupt pin
  input  wire logic        phy_irq_pin,
  // MAC events, system clock
  input  wire logic        tx_fcs_bad,
  input  wire logic [2:0]  stamp_ready,
  input  wire logic        rx_ovf,
  input  wire logic        tx_starved,
  input  wire logic        tx_wr_byte,
  input  wire logic        tx_rd_byte,
  input  wire logic        tx_sof,
  input  wire logic        len_wr,
  input  wire logic        len_pending,
  // SPI front end, link clock
  input  wire logic        chunk_stb,
  input  wire logic        chunk_dv,
  input  wire logic        chunk_sv,
  input  wire logic        chunk_ev,
  input  wire logic        hdr_par_bad,
  input  wire logic        cs_early,
  input  wire logic        cdp_bad,
  input  wire logic        acc_stb,
  input  wire logic        acc_wr,
  input  wire logic [7:0]  acc_addr,
  input  wire logic [31:0] acc_wdata,
  // Host-facing and MAC-facing results
  output logic             irq_out_n,
  output logic             exst,
  output logic             tx_stop,
  output logic             tx_discard,
  output logic             lk_busy,
  output logic             lk_rvalid,
  output logic [31:0]      lk_rdata
);
  // ==========================================================
  // Link clock reset release
  logic lk_r1_reg, lk_rst_b;

  always_ff @(posedge lk_clk or negedge rst_b) begin
    if (!rst_b) begin
      lk_r1_reg <= 1'b0;
      lk_rst_b  <= 1'b0;
    end else begin
      lk_r1_reg <= 1'b1;
      lk_rst_b  <= lk_r1_reg;
    end
  end

  // ==========================================================
  // Link side: chunk framing and event pulses
  mps_pkg::mps_frame_t  fr_reg, fr_next;
  mps_pkg::mps_lk_evt_t lk_evt;
  mps_pkg::mps_lk_evt_t sys_evt;
  mps_pkg::mps_acc_t    lk_acc;
  mps_pkg::mps_acc_t    sys_acc;
  logic                 lk_go, lk_done, sys_stb;
  logic                 lk_busy_next, lk_rvalid_next, lk_rd_pend_reg, lk_rd_pend_next;
  logic [31:0]          lk_rdata_next;
  logic [31:0]          rd_word_reg, rd_word_next;

  always_comb begin
    fr_next = fr_reg;
    lk_evt  = '0;
    if (chunk_stb && chunk_dv) begin
      lk_evt.chunk_order = (!chunk_sv && fr_reg == mps_pkg::MPS_FR_IDLE) ||
                           (chunk_sv && fr_reg == mps_pkg::MPS_FR_OPEN);
      case (fr_reg)
        mps_pkg::MPS_FR_IDLE: fr_next = (chunk_sv && !chunk_ev) ? mps_pkg::MPS_FR_OPEN : fr_reg;
        mps_pkg::MPS_FR_OPEN: fr_next = chunk_ev ? mps_pkg::MPS_FR_IDLE : fr_reg;
        default:              fr_next = mps_pkg::MPS_FR_IDLE;
      endcase
    end
    lk_evt.hdr_parity   = hdr_par_bad;
    lk_evt.frame_loss   = cs_early;
    lk_evt.ctrl_protect = cdp_bad;
    lk_go           = acc_stb && !lk_busy;
    lk_acc.wr       = acc_wr;
    lk_acc.addr     = acc_addr;
    lk_acc.wdata    = acc_wdata;
    lk_busy_next    = lk_go ? 1'b1 : (lk_done ? 1'b0 : lk_busy);
    lk_rd_pend_next = lk_go ? !acc_wr : (lk_done ? 1'b0 : lk_rd_pend_reg);
    lk_rvalid_next  = lk_done && lk_rd_pend_reg;
    // Reply word is held still by the system side until the next request
    lk_rdata_next   = lk_rvalid_next ? rd_word_reg : lk_rdata;
  end

  always_ff @(posedge lk_clk or negedge lk_rst_b) begin
    if (!lk_rst_b) begin
      fr_reg         <= mps_pkg::MPS_FR_IDLE;
      lk_busy        <= 1'b0;
      lk_rd_pend_reg <= 1'b0;
      lk_rvalid      <= 1'b0;
      lk_rdata       <= 32'h0000_0000;
    end else begin
      fr_reg         <= fr_next;
      lk_busy        <= lk_busy_next;
      lk_rd_pend_reg <= lk_rd_pend_next;
      lk_rvalid      <= lk_rvalid_next;
      lk_rdata       <= lk_rdata_next;
    end
  end

  // ==========================================================
  // Crossings
  mps_evt_cdc #(.W(4)) u_evt (
    .src_clk   (lk_clk),
    .src_rst_b (lk_rst_b),
    .src_pulse (lk_evt),
    .dst_clk   (clk),
    .dst_rst_b (rst_b),
    .dst_pulse (sys_evt)
  );

  mps_hs_cdc #(.W(41)) u_acc (
    .src_clk   (lk_clk),
    .src_rst_b (lk_rst_b),
    .src_go    (lk_go),
    .src_data  (lk_acc),
    .src_done  (lk_done),
    .dst_clk   (clk),
    .dst_rst_b (rst_b),
    .dst_stb   (sys_stb),
    .dst_data  (sys_acc)
  );

  // ==========================================================
  // System side: flags, FIFO fill and outputs
  logic [12:0] flags_reg, flags_next, set_vec, clr_vec, view;
  logic [12:0] used_reg, used_next, frm_reg, frm_next;
  logic        phy_s1_reg, phy_s2_reg;
  logic        full, wr_ok, ovf_ev;
  logic        irq_next, exst_next, stop_next, discard_next;

  always_comb begin
    full  = (used_reg == `MPS_TX_FIFO_BYTES);
    // Writes resume only at start of frame
    wr_ok  = tx_wr_byte && (!tx_discard || tx_sof);
    ovf_ev = wr_ok && full;
    used_next = used_reg;
    if (ovf_ev) begin
      used_next = used_reg - frm_reg - {12'h000, tx_rd_byte};
    end else begin
      used_next = used_reg + {12'h000, wr_ok} - {12'h000, tx_rd_byte};
    end
    frm_next = tx_sof ? {12'h000, wr_ok && !full} : frm_reg + {12'h000, wr_ok && !full};
    discard_next = ovf_ev ? 1'b1 : (tx_sof ? 1'b0 : tx_discard);

    set_vec = '0;
    set_vec[`MPS_BIT_CTRL_PROTECT] = CDP_IMPL && cdp_en && proto_std && sys_evt.ctrl_protect;
    set_vec[`MPS_BIT_TX_CHECKSUM]  = tx_fcs_bad;
    set_vec[`MPS_BIT_STAMP_C]      = stamp_ready[2];
    set_vec[`MPS_BIT_STAMP_B]      = stamp_ready[1];
    set_vec[`MPS_BIT_STAMP_A]      = stamp_ready[0];
    set_vec[`MPS_BIT_HDR_PARITY]   = proto_std && sys_evt.hdr_parity;
    set_vec[`MPS_BIT_FRAME_LOSS]   = sys_evt.frame_loss || set_vec[`MPS_BIT_CTRL_PROTECT];
    set_vec[`MPS_BIT_RX_OVERFLOW]  = rx_ovf;
    set_vec[`MPS_BIT_TX_UNDERRUN]  = cut_through_en && tx_starved;
    set_vec[`MPS_BIT_TX_OVERFLOW]  = ovf_ev;
    set_vec[`MPS_BIT_TX_PROTOCOL]  = proto_std ? sys_evt.chunk_order : (len_wr && len_pending);

    clr_vec = '0;
    if (sys_stb && sys_acc.wr && sys_acc.addr == `MPS_FLAGS_OFS) begin
      clr_vec = sys_acc.wdata[12:0];
    end
    flags_next = (flags_reg & ~clr_vec) | set_vec;
    flags_next[`MPS_BIT_PHY_IRQ] = 1'b0;
    if (!CDP_IMPL) begin
      flags_next[`MPS_BIT_CTRL_PROTECT] = 1'b0;
    end

    view = flags_reg;
    view[`MPS_BIT_PHY_IRQ] = phy_s2_reg;
    rd_word_next = rd_word_reg;
    if (sys_stb && !sys_acc.wr) begin
      rd_word_next = (sys_acc.addr == `MPS_FLAGS_OFS) ? {19'h00000, view} : 32'h0000_0000;
    end
    irq_next  = !(view[`MPS_BIT_RESET_DONE] || |(view & irq_unmask));
    exst_next = flags_reg[`MPS_BIT_RESET_DONE] && !exst_mask;
    stop_next = set_vec[`MPS_BIT_TX_UNDERRUN];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_reg   <= `MPS_FLAGS_RST;
      used_reg    <= 13'h0000;
      frm_reg     <= 13'h0000;
      phy_s1_reg  <= 1'b0;
      phy_s2_reg  <= 1'b0;
      rd_word_reg <= 32'h0000_0000;
      irq_out_n   <= 1'b1;
      exst        <= 1'b0;
      tx_stop     <= 1'b0;
      tx_discard  <= 1'b0;
    end else begin
      flags_reg   <= flags_next;
      used_reg    <= used_next;
      frm_reg     <= frm_next;
      phy_s1_reg  <= phy_irq_pin;
      phy_s2_reg  <= phy_s1_reg;
      rd_word_reg <= rd_word_next;
      irq_out_n   <= irq_next;
      exst        <= exst_next;
      tx_stop     <= stop_next;
      tx_discard  <= discard_next;
    end
  end

  // ==========================================================
  // Checks
  property p_cdp_set;
    @(posedge clk) disable iff (!rst_b)
    (CDP_IMPL && cdp_en && proto_std && sys_evt.ctrl_protect) |=> flags_reg[12];
  endproperty
  a_cdp_set: assert property (p_cdp_set) else $error("protection flag not set");

  property p_cdp_absent;
    @(posedge clk) disable iff (!rst_b)
    !CDP_IMPL |-> !flags_reg[12] && !rd_word_reg[12];
  endproperty
  a_cdp_absent: assert property (p_cdp_absent) else $error("absent flag not zero");

  property p_fcs;
    @(posedge clk) disable iff (!rst_b)
    tx_fcs_bad |=> flags_reg[11];
  endproperty
  a_fcs: assert property (p_fcs) else $error("checksum flag not set");

  property p_irq_reset_done;
    @(posedge clk) disable iff (!rst_b)
    flags_reg[6] |=> !irq_out_n;
  endproperty
  a_irq_reset_done: assert property (p_irq_reset_done) else $error("irq not low");

  property p_exst;
    @(posedge clk) disable iff (!rst_b)
    $fell(flags_reg[6]) |=> !exst;
  endproperty
  a_exst: assert property (p_exst) else $error("exst not dropped");

  property p_loss_follows;
    @(posedge clk) disable iff (!rst_b)
    $rose(flags_reg[12]) |-> flags_reg[4];
  endproperty
  a_loss_follows: assert property (p_loss_follows) else $error("loss flag missing");

  property p_underrun_mode;
    @(posedge clk) disable iff (!rst_b)
    !cut_through_en && !flags_reg[2] |=> !flags_reg[2] && !tx_stop;
  endproperty
  a_underrun_mode: assert property (p_underrun_mode) else $error("underrun outside mode");

  property p_ovf_discard;
    @(posedge clk) disable iff (!rst_b)
    ovf_ev ##1 !tx_sof |-> tx_discard && flags_reg[1] ##1 tx_discard;
  endproperty
  a_ovf_discard: assert property (p_ovf_discard) else $error("overflow not held");

  property p_fifo_bound;
    @(posedge clk) disable iff (!rst_b)
    used_reg <= `MPS_TX_FIFO_BYTES;
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("fill above size");

  property p_sticky;
    @(posedge clk) disable iff (!rst_b)
    1'b1 |=> ($past(flags_reg) & ~$past(clr_vec) & ~flags_reg & 13'h1F7F) == 13'h0000;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without clear");

  property p_reserved;
    @(posedge clk) disable iff (!rst_b)
    rd_word_reg[31:13] == 19'h00000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_chunk_order;
    @(posedge lk_clk) disable iff (!lk_rst_b)
    chunk_stb && chunk_dv && chunk_sv && fr_reg == mps_pkg::MPS_FR_OPEN |-> lk_evt.chunk_order;
  endproperty
  a_chunk_order: assert property (p_chunk_order) else $error("repeated start missed");
endmodule
`default_nettype wire

// >>> tb/mps_host_model.sv
// Host-side model: register accesses and link events on the link clock
`default_nettype none
module mps_host_model (
  // Link clock and answers
  input  wire logic        lk_clk,
  input  wire logic        lk_busy,
  input  wire logic        lk_rvalid,
  input  wire logic [31:0] lk_rdata,
  // Register access request
  output logic             acc_stb,
  output logic             acc_wr,
  output logic [7:0]       acc_addr,
  output logic [31:0]      acc_wdata,
  // Link events {cdp, hdr, cs, stb, dv, sv, ev}
  output logic [6:0]       lev
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    acc_stb = 1'b0;
    acc_wr = 1'b0;
    acc_addr = 8'h00;
    acc_wdata = 32'h0000_0000;
    lev = 7'h00;
  end
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
    int n;
    n = 0;
    @(posedge lk_clk);
    acc_stb <= 1'b1;
    acc_wr <= w;
    acc_addr <= a;
    acc_wdata <= d;
    // Taken at the first edge that sees the block idle
    do begin
      @(posedge lk_clk);
      n++;
    end while (lk_busy === 1'b1 && n < 200);
    acc_stb <= 1'b0;
    acc_wr <= ~w;
    acc_addr <= ~a;
    acc_wdata <= ~d;
    // Answer edge: busy seen low, read valid seen high only for reads
    do begin
      @(posedge lk_clk);
      n++;
    end while (lk_busy !== 1'b0 && n < 200);
    r = (lk_rvalid === !w) ? lk_rdata : 32'hXXXX_XXXX;
  endtask
  task automatic lk_pulse(input logic [6:0] v);
    @(posedge lk_clk);
    lev <= v;
    @(posedge lk_clk);
    lev <= 7'h00;
  endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the status flag register
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0]  cfg;
    logic [6:0]  cev;
    logic [6:0]  lev;
    logic [12:0] exp;
  } mps_row_t;
  logic        clk, lk_clk, rst_b, proto_std, cdp_en, cut_through_en, exst_mask;
  logic        phy_irq_pin, tx_wr_byte, tx_sof, irq_out_n, exst, tx_stop, tx_discard;
  logic        lk_busy, lk_rvalid, acc_stb, acc_wr;
  logic [12:0] irq_unmask;
  logic [6:0]  cev, lev;
  logic [7:0]  acc_addr;
  logic [31:0] acc_wdata, lk_rdata, q;
  int          mismatches = 0;
  int          num_checks = 0;
  int          stops = 0;
  // Rows: {proto_std, cdp_en, cut}, clk events, link events, expected flags
  // Cut-through also raises len_pending
  localparam mps_row_t ROWS [20] = '{
    '{3'b110, 7'h01, 7'h00, 13'h0800},
    '{3'b110, 7'h02, 7'h00, 13'h0100},
    '{3'b110, 7'h04, 7'h00, 13'h0200},
    '{3'b110, 7'h08, 7'h00, 13'h0400},
    '{3'b110, 7'h10, 7'h00, 13'h0008},
    '{3'b111, 7'h20, 7'h00, 13'h0004},
    '{3'b110, 7'h20, 7'h00, 13'h0000},
    '{3'b011, 7'h40, 7'h00, 13'h0001},
    '{3'b010, 7'h40, 7'h00, 13'h0000},
    '{3'b110, 7'h40, 7'h00, 13'h0000},
    '{3'b110, 7'h00, 7'h40, 13'h1010},
    '{3'b110, 7'h00, 7'h20, 13'h0020},
    '{3'b010, 7'h00, 7'h20, 13'h0000},
    '{3'b110, 7'h00, 7'h10, 13'h0010},
    '{3'b110, 7'h00, 7'h0E, 13'h0000},
    '{3'b110, 7'h00, 7'h0E, 13'h0001},
    '{3'b110, 7'h00, 7'h0D, 13'h0000},
    '{3'b110, 7'h00, 7'h0C, 13'h0001},
    '{3'b010, 7'h00, 7'h0C, 13'h0000},
    '{3'b100, 7'h00, 7'h40, 13'h0000}
  };
  mps_status_flags #(.CDP_IMPL(1'b1)) dut (
    .clk(clk), .lk_clk(lk_clk), .rst_b(rst_b), .proto_std(proto_std), .cdp_en(cdp_en),
    .cut_through_en(cut_through_en), .exst_mask(exst_mask), .irq_unmask(irq_unmask),
    .phy_irq_pin(phy_irq_pin), .tx_fcs_bad(cev[0]), .stamp_ready(cev[3:1]),
    .rx_ovf(cev[4]), .tx_starved(cev[5]), .tx_wr_byte(tx_wr_byte), .tx_rd_byte(1'b0),
    .tx_sof(tx_sof), .len_wr(cev[6]), .len_pending(cut_through_en), .chunk_stb(lev[3]),
    .chunk_dv(lev[2]), .chunk_sv(lev[1]), .chunk_ev(lev[0]), .hdr_par_bad(lev[5]),
    .cs_early(lev[4]), .cdp_bad(lev[6]), .acc_stb(acc_stb), .acc_wr(acc_wr),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .irq_out_n(irq_out_n), .exst(exst),
    .tx_stop(tx_stop), .tx_discard(tx_discard), .lk_busy(lk_busy),
    .lk_rvalid(lk_rvalid), .lk_rdata(lk_rdata));
  mps_host_model host (
    .lk_clk(lk_clk), .lk_busy(lk_busy), .lk_rvalid(lk_rvalid), .lk_rdata(lk_rdata),
    .acc_stb(acc_stb),
    .acc_wr(acc_wr), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .lev(lev));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    lk_clk = 1'b0;
    #7;
    forever #24 lk_clk = ~lk_clk;
  end
  always @(posedge clk) if (tx_stop === 1'b1) stops <= stops + 1;
  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    host.access(1'b0, a, 32'h0000_0000, q);
  endtask
  task automatic wr(input logic [31:0] d);
    logic [31:0] r;
    host.access(1'b1, 8'h08, d, r);
    chk1("write ack", 1'b0, $isunknown(r));
  endtask
  task automatic fire(input logic [6:0] c, input logic [6:0] l);
    if (c != 7'h00) begin
      @(posedge clk);
      cev <= c;
      @(posedge clk);
      cev <= 7'h00;
    end
    if (l != 7'h00) host.lk_pulse(l);
  endtask
  task automatic pulse_wr(input logic sof);
    @(posedge clk);
    tx_wr_byte <= 1'b1;
    tx_sof <= sof;
    @(posedge clk);
    tx_wr_byte <= 1'b0;
    tx_sof <= 1'b0;
    clks(3);
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst_b <= 1'b0;
    clks(3);
    rst_b <= 1'b1;
    repeat (6) @(posedge lk_clk);
    clks(2);
  endtask
  initial begin
    #2_000_000;
    mismatches++;
    stop_test;
  end
  initial begin
    rst_b = 1'b0;
    {proto_std, cdp_en, cut_through_en} = 3'b110;
    exst_mask = 1'b0;
    phy_irq_pin = 1'b0;
    tx_wr_byte = 1'b0;
    tx_sof = 1'b0;
    irq_unmask = 13'h0000;
    cev = 7'h00;
    do_reset;
    rd(8'h08);
    chk32("reset flags", 32'h0000_0040, q);
    chk1("irq reset", 1'b0, irq_out_n);
    chk1("exst reset", 1'b1, exst);
    wr(32'h0000_0040);
    clks(4);
    chk1("exst cleared", 1'b0, exst);
    chk1("irq cleared", 1'b1, irq_out_n);
    @(posedge clk) irq_unmask <= 13'h1FFF;
    foreach (ROWS[i]) begin
      @(posedge clk) {proto_std, cdp_en, cut_through_en} <= ROWS[i].cfg;
      wr(32'hFFFF_FFFF);
      fire(ROWS[i].cev, ROWS[i].lev);
      clks(10);
      rd(8'h08);
      chk32("row flags", {19'h0, ROWS[i].exp}, q);
      chk1("row irq", ROWS[i].exp == 13'h0000, irq_out_n);
    end
    @(posedge clk) phy_irq_pin <= 1'b1;
    clks(4);
    wr(32'hFFFF_FFFF);
    rd(8'h08);
    chk32("phy bit", 32'h0000_0080, q);
    chk1("phy irq", 1'b0, irq_out_n);
    rd(8'h0C);
    chk32("unmapped", 32'h0000_0000, q);
    @(posedge clk) phy_irq_pin <= 1'b0;
    fire(7'h01, 7'h00);
    clks(50);
    wr(32'h0000_07FF);
    rd(8'h08);
    chk32("sticky", 32'h0000_0800, q);
    @(posedge clk) irq_unmask <= 13'h0000;
    clks(3);
    chk1("masked irq", 1'b1, irq_out_n);
    wr(32'h0000_0800);
    rd(8'h08);
    chk32("cleared", 32'h0000_0000, q);
    chk32("underrun stops", 32'h0000_0001, 32'(stops));
    // one byte per clock, faster than the line rate
    for (int k = 0; k < 4096; k++) begin
      @(posedge clk);
      tx_wr_byte <= 1'b1;
      tx_sof <= (k == 0);
    end
    @(posedge clk);
    tx_wr_byte <= 1'b0;
    tx_sof <= 1'b0;
    rd(8'h08);
    chk32("fifo full", 32'h0000_0000, q);
    chk1("no discard", 1'b0, tx_discard);
    pulse_wr(1'b0);
    chk1("discard", 1'b1, tx_discard);
    rd(8'h08);
    chk32("overflow", 32'h0000_0002, q);
    pulse_wr(1'b0);
    chk1("still discard", 1'b1, tx_discard);
    pulse_wr(1'b1);
    chk1("sof resumes", 1'b0, tx_discard);
    @(posedge clk) exst_mask <= 1'b1;
    do_reset;
    chk1("exst masked", 1'b0, exst);
    chk1("irq unmaskable", 1'b0, irq_out_n);
    rd(8'h08);
    chk32("reset again", 32'h0000_0040, q);
    @(posedge clk) exst_mask <= 1'b0;
    clks(3);
    chk1("exst unmasked", 1'b1, exst);
    stop_test;
  end
endmodule
`default_nettype wire
